// *** rtl/tgs_top.sv ***
/*
  tgs_top: traffic generator pattern configuration and status, with the
  write/read loop engine that drives a word-addressed host port.
  assumes: APB master on the same clock; host port answers on this clock,
  returning read beats in order and only while a read is outstanding.
*/
`timescale 1ns/1ps
module tgs_top (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire tgs_pkg::tgs_apb_req_t APB_REQ_IN,
  output tgs_pkg::tgs_apb_rsp_t APB_RSP_OUT,
  output tgs_pkg::tgs_cmd_t HOST_CMD_OUT,
  input wire tgs_pkg::tgs_host_rsp_t HOST_RSP_IN
);
  tgs_pkg::tgs_regs_t q;
  tgs_pkg::tgs_regs_t n;
  logic [tgs_pkg::AW-1:0] addr;
  logic [tgs_pkg::AW:0] sum;
  logic [3:0] bl;
  logic [3:0] clip;
  logic over;
  logic do_fadv;
  logic do_dadv;
  logic do_save;
  logic do_rest;
  logic [31:0] rd;
  logic hit;
  logic [31:0] cfg_err;
  logic [tgs_pkg::RDW-1:0] mism;
  logic [4:0] need;

  // one step of a data or mask pattern generator
  function automatic logic [31:0] gen_step(input logic [5:0] sel,
                                           input logic [31:0] s);
    logic [31:0] r;
    r = s;
    case (sel)
      tgs_pkg::PAT_PRBS7: r = {s[30:0], s[6] ^ s[5]};
      tgs_pkg::PAT_PRBS15: r = {s[30:0], s[14] ^ s[13]};
      tgs_pkg::PAT_PRBS31: r = {s[30:0], s[30] ^ s[27]};
      tgs_pkg::PAT_ROT: r = {s[30:0], s[31]};
      default: r = s;
    endcase
    return r;
  endfunction

  // xnor lfsr, locks only on all ones
  function automatic logic [tgs_pkg::AW-1:0] lfsr(
      input logic [tgs_pkg::AW-1:0] v);
    return {v[tgs_pkg::AW-2:0], ~(v[25] ^ v[5] ^ v[1] ^ v[0])};
  endfunction

  function automatic logic [tgs_pkg::AW-1:0] assemble(
      input logic [tgs_pkg::NF-1:0][tgs_pkg::AW-1:0] fv,
      input logic [tgs_pkg::NF-2:0][5:0] tb);
    logic [tgs_pkg::AW-1:0] a;
    int lo;
    int hi;
    a = '0;
    lo = 0;
    for (int f = 0; f < tgs_pkg::NF; f++) begin
      // last field ends at top address bit
      hi = (f < tgs_pkg::NF - 1) ? int'(tb[f]) : tgs_pkg::AW - 1;
      for (int b = 0; b < tgs_pkg::AW; b++) begin
        if (b >= lo && b <= hi) begin
          a[b] = fv[f][b - lo];
        end
      end
      lo = hi + 1;
    end
    return a;
  endfunction

  always_comb begin
    need = '0;
    for (int k = 0; k < 4; k++) begin
      if ((5'h1 << k) < {1'b0, bl}) begin
        need = 5'(k + 1);
      end
    end
    cfg_err = '0;
    if ({1'b0, q.topbit[0]} + 7'h1 < {2'b00, need}) begin
      cfg_err[tgs_pkg::ERR_FIELD0] = 1'b1;
    end
    for (int f = 0; f < tgs_pkg::NF - 1; f++) begin
      if (q.topbit[f] >= 6'(tgs_pkg::AW - 1) ||
          (f > 0 && q.topbit[f] <= q.topbit[(f > 0) ? f - 1 : 0])) begin
        cfg_err[tgs_pkg::ERR_TOPBIT] = 1'b1;
      end
    end
  end

  always_comb begin
    // register read mux
    rd = '0;
    hit = 1'b1;
    case (APB_REQ_IN.paddr)
      tgs_pkg::OFF_CFG_ERR: rd = cfg_err;
      tgs_pkg::OFF_RATIO: rd = {28'h0, tgs_pkg::WIDTH_RATIO_VAL};
      tgs_pkg::OFF_OVF: rd = {31'h0, q.ovf};
      tgs_pkg::OFF_OVF_LO: rd = 32'(q.ovf_addr);
      tgs_pkg::OFF_OVF_HI: rd = 32'h0;
      tgs_pkg::OFF_CTRL: rd = {8'h0, q.loops, q.ops, q.blen, 2'b00,
                               q.write_once_read_many_en, 1'b0};
      tgs_pkg::OFF_STAT: rd = {29'h0, q.failed, q.done, q.busy};
      tgs_pkg::OFF_MODE: rd = 32'(q.amode);
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < tgs_pkg::NW; i++) begin
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_PASS + 12'(4 * i)) begin
        rd = q.pass_vec[32*i +: 32];
        hit = 1'b1;
      end
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_FEXP + 12'(4 * i)) begin
        rd = q.fexp[32*i +: 32];
        hit = 1'b1;
      end
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_FRCV + 12'(4 * i)) begin
        rd = q.frcv[32*i +: 32];
        hit = 1'b1;
      end
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_REREAD + 12'(4 * i)) begin
        rd = q.reread[32*i +: 32];
        hit = 1'b1;
      end
    end
    for (int i = 0; i < tgs_pkg::NDG; i++) begin
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_DSEED + 12'(4 * i)) begin
        rd = q.dseed[i];
        hit = 1'b1;
      end
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_DSEL + 12'(4 * i)) begin
        rd = {26'h0, q.dsel[i]};
        hit = 1'b1;
      end
    end
    for (int i = 0; i < tgs_pkg::NMG; i++) begin
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_MSEED + 12'(4 * i)) begin
        rd = q.mseed[i];
        hit = 1'b1;
      end
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_MSEL + 12'(4 * i)) begin
        rd = {26'h0, q.msel[i]};
        hit = 1'b1;
      end
    end
    for (int i = 0; i < tgs_pkg::NF; i++) begin
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_INTV + 12'(4 * i)) begin
        rd = {16'h0, q.intv[i]};
        hit = 1'b1;
      end
      if (i < tgs_pkg::NF - 1 &&
          APB_REQ_IN.paddr == tgs_pkg::OFF_TOPBIT + 12'(4 * i)) begin
        rd = {26'h0, q.topbit[(i < tgs_pkg::NF - 1) ? i : 0]};
        hit = 1'b1;
      end
    end
  end

  always_comb begin
    n = q;
    do_fadv = 1'b0;
    do_dadv = 1'b0;
    do_save = 1'b0;
    do_rest = 1'b0;
    bl = (q.blen == 4'h0) ? 4'h1 : q.blen;
    addr = assemble(q.fval, q.topbit);
    sum = {1'b0, addr} + {{(tgs_pkg::AW - 3){1'b0}}, bl};
    over = sum[tgs_pkg::AW] && (sum[tgs_pkg::AW-1:0] != '0);
    clip = 4'(~addr + {{(tgs_pkg::AW - 1){1'b0}}, 1'b1});
    mism = q.cmd.valid ? '0 : (HOST_RSP_IN.rdata ^ q.cmd.wdata);
    // apb slave: ready one cycle into access, write at ready edge
    if (APB_REQ_IN.psel && APB_REQ_IN.penable && !q.apb.pready) begin
      n.apb.pready = 1'b1;
      n.apb.prdata = rd;
      n.apb.pslverr = !hit;
    end else begin
      n.apb.pready = 1'b0;
      n.apb.pslverr = 1'b0;
    end
    if (APB_REQ_IN.psel && APB_REQ_IN.penable && q.apb.pready &&
        APB_REQ_IN.pwrite) begin
      for (int i = 0; i < tgs_pkg::NDG; i++) begin
        if (APB_REQ_IN.paddr == tgs_pkg::OFF_DSEED + 12'(4 * i)) begin
          n.dseed[i] = APB_REQ_IN.pwdata;
        end
        if (APB_REQ_IN.paddr == tgs_pkg::OFF_DSEL + 12'(4 * i)) begin
          n.dsel[i] = APB_REQ_IN.pwdata[5:0];
        end
      end
      for (int i = 0; i < tgs_pkg::NMG; i++) begin
        if (APB_REQ_IN.paddr == tgs_pkg::OFF_MSEED + 12'(4 * i)) begin
          n.mseed[i] = APB_REQ_IN.pwdata;
        end
        if (APB_REQ_IN.paddr == tgs_pkg::OFF_MSEL + 12'(4 * i)) begin
          n.msel[i] = APB_REQ_IN.pwdata[5:0];
        end
      end
      for (int i = 0; i < tgs_pkg::NF; i++) begin
        if (APB_REQ_IN.paddr == tgs_pkg::OFF_INTV + 12'(4 * i)) begin
          n.intv[i] = APB_REQ_IN.pwdata[15:0];
        end
        // field top bits for fields 0 to 4
        if (i < tgs_pkg::NF - 1 &&
            APB_REQ_IN.paddr == tgs_pkg::OFF_TOPBIT + 12'(4 * i)) begin
          n.topbit[(i < tgs_pkg::NF - 1) ? i : 0] = APB_REQ_IN.pwdata[5:0];
        end
      end
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_MODE) begin
        n.amode = APB_REQ_IN.pwdata[2*tgs_pkg::NF-1:0];
      end
      if (APB_REQ_IN.paddr == tgs_pkg::OFF_CTRL) begin
        n.write_once_read_many_en = APB_REQ_IN.pwdata[tgs_pkg::CTRL_WRITE_ONCE_READ_MANY];
        n.blen = APB_REQ_IN.pwdata[tgs_pkg::CTRL_BLEN_LO +: 4];
        n.ops = APB_REQ_IN.pwdata[tgs_pkg::CTRL_OPS_LO +: 8];
        n.loops = APB_REQ_IN.pwdata[tgs_pkg::CTRL_LOOPS_LO +: 8];
        if (APB_REQ_IN.pwdata[tgs_pkg::CTRL_START] && !q.busy) begin
          n.st = tgs_pkg::ST_WR_SET;
          n.busy = 1'b1;
          n.done = 1'b0;
          n.failed = 1'b0;
          n.ovf = 1'b0;
          n.ovf_addr = '0;
          n.ff_addr = '0;
          n.pass_vec = '1;
          n.fexp = '0;
          n.frcv = '0;
          n.reread = '0;
          n.dst = q.dseed;
          n.mst = q.mseed;
          n.fval = '0;
          n.fcnt = '0;
          n.loop_left = (APB_REQ_IN.pwdata[23:16] == 8'h0) ? 8'h1 :
                        APB_REQ_IN.pwdata[23:16];
          n.op_left = (APB_REQ_IN.pwdata[15:8] == 8'h0) ? 8'h1 :
                      APB_REQ_IN.pwdata[15:8];
          do_save = 1'b1;
        end
      end
    end
    unique case (q.st)
      tgs_pkg::ST_IDLE: begin
        n.busy = q.busy;
      end
      tgs_pkg::ST_WR_SET: begin
        n.cmd.valid = 1'b1;
        n.cmd.write = 1'b1;
        n.cmd.addr = addr;
        n.cmd.burst = over ? clip : bl;
        n.cur_bl = over ? clip : bl;
        n.beat_left = over ? clip : bl;
        if (over && !q.ovf) begin
          n.ovf = 1'b1;
          n.ovf_addr = addr;
        end
        n.st = tgs_pkg::ST_WR_BEAT;
      end
      tgs_pkg::ST_WR_BEAT: begin
        if (HOST_RSP_IN.ready) begin
          do_dadv = 1'b1;
          n.beat_left = q.beat_left - 4'h1;
          if (q.beat_left == 4'h1) begin
            n.cmd.valid = 1'b0;
            do_fadv = 1'b1;
            n.op_left = q.op_left - 8'h1;
            n.st = tgs_pkg::ST_WR_SET;
            if (q.op_left == 8'h1) begin
              do_rest = 1'b1;
              n.op_left = (q.ops == 8'h0) ? 8'h1 : q.ops;
              n.st = tgs_pkg::ST_RD_SET;
            end
          end
        end
      end
      tgs_pkg::ST_RD_SET: begin
        n.cmd.valid = 1'b1;
        n.cmd.write = 1'b0;
        n.cmd.addr = addr;
        n.cmd.burst = over ? clip : bl;
        n.cur_bl = over ? clip : bl;
        n.beat_left = over ? clip : bl;
        n.st = tgs_pkg::ST_RD_CMD;
      end
      tgs_pkg::ST_RD_CMD: begin
        if (HOST_RSP_IN.ready) begin
          n.cmd.valid = 1'b0;
          n.st = tgs_pkg::ST_RD_BEAT;
        end
      end
      tgs_pkg::ST_RD_BEAT: begin
        if (HOST_RSP_IN.rvalid) begin
          do_dadv = 1'b1;
          n.pass_vec = q.pass_vec & ~mism;
          if (mism != '0 && !q.failed) begin
            n.fexp = q.cmd.wdata;
            n.frcv = HOST_RSP_IN.rdata;
            n.failed = 1'b1;
            n.ff_addr = q.cmd.addr +
                        tgs_pkg::AW'(q.cur_bl - q.beat_left);
          end
          n.beat_left = q.beat_left - 4'h1;
          if (q.beat_left == 4'h1) begin
            do_fadv = 1'b1;
            n.op_left = q.op_left - 8'h1;
            n.st = tgs_pkg::ST_RD_SET;
            if (q.op_left == 8'h1) begin
              n.op_left = (q.ops == 8'h0) ? 8'h1 : q.ops;
              n.loop_left = q.loop_left - 8'h1;
              n.st = tgs_pkg::ST_WR_SET;
              do_save = 1'b1;
              if (q.loop_left == 8'h1) begin
                n.st = tgs_pkg::ST_IDLE;
                n.busy = 1'b0;
                n.done = 1'b1;
                if (q.write_once_read_many_en && (q.failed || mism != '0)) begin
                  n.st = tgs_pkg::ST_WRITE_ONCE_READ_MANY_CMD;
                  n.busy = 1'b1;
                  n.done = 1'b0;
                  n.cmd.valid = 1'b1;
                  n.cmd.write = 1'b0;
                  n.cmd.burst = 4'h1;
                  n.cmd.addr = q.failed ? q.ff_addr : n.ff_addr;
                end
              end
            end
          end
        end
      end
      tgs_pkg::ST_WRITE_ONCE_READ_MANY_CMD: begin
        if (HOST_RSP_IN.ready) begin
          n.cmd.valid = 1'b0;
          n.st = tgs_pkg::ST_WRITE_ONCE_READ_MANY_BEAT;
        end
      end
      tgs_pkg::ST_WRITE_ONCE_READ_MANY_BEAT: begin
        if (HOST_RSP_IN.rvalid) begin
          n.reread = HOST_RSP_IN.rdata;
          n.st = tgs_pkg::ST_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end
    endcase
    if (do_dadv) begin
      for (int i = 0; i < tgs_pkg::NDG; i++) begin
        n.dst[i] = gen_step(q.dsel[i], q.dst[i]);
      end
      if (q.cmd.write) begin
        for (int i = 0; i < tgs_pkg::NMG; i++) begin
          n.mst[i] = gen_step(q.msel[i], q.mst[i]);
        end
      end
    end
    if (do_fadv) begin
      for (int f = 0; f < tgs_pkg::NF; f++) begin
        // new value once every interval ops
        if ({1'b0, q.fcnt[f]} + 17'h1 >= {1'b0, q.intv[f]}) begin
          n.fcnt[f] = '0;
          case (q.amode[f])
            tgs_pkg::AMODE_RANDOM: n.fval[f] = lfsr(q.fval[f]);
            tgs_pkg::AMODE_SEQ: n.fval[f] = q.fval[f] +
                (f == 0 ? tgs_pkg::AW'(bl) : tgs_pkg::AW'(1));
            tgs_pkg::AMODE_UNUSED: n.fval[f] = '0;
            default: n.fval[f] = q.fval[f];
          endcase
        end else begin
          n.fcnt[f] = q.fcnt[f] + 16'h1;
        end
      end
    end
    if (do_rest) begin
      n.dst = q.dsave;
      n.fval = q.fsave;
      n.fcnt = q.fcsave;
    end
    if (do_save) begin
      n.dsave = n.dst;
      n.fsave = n.fval;
      n.fcsave = n.fcnt;
    end
    if (n.st != tgs_pkg::ST_WRITE_ONCE_READ_MANY_CMD && n.st != tgs_pkg::ST_WRITE_ONCE_READ_MANY_BEAT) begin
      n.cmd.wdata = n.dst;
    end
    n.cmd.byteen = n.mst[0][tgs_pkg::BEW-1:0];
  end

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      q <= '0;
      q.st <= tgs_pkg::ST_IDLE;
      q.blen <= tgs_pkg::BLEN_RST;
      q.ops <= tgs_pkg::OPS_RST;
      q.loops <= tgs_pkg::LOOPS_RST;
      q.intv <= {tgs_pkg::NF{tgs_pkg::INTV_RST}};
      q.pass_vec <= '1;
    end else begin
      q <= n;
    end
  end

  assign APB_RSP_OUT = q.apb;
  assign HOST_CMD_OUT = q.cmd;
endmodule

// *** rtl/tgs_pkg.sv ***
/*
  tgs_pkg: constants, register map and carrier types of the traffic
  generator status and pattern block.
  assumes: one 125 MHz clock shared with the memory controller host port.
*/
package tgs_pkg;
  localparam int AW = 26;
  localparam int RDW = 64;
  localparam int NW = RDW / 32;
  localparam int NDG = 2;
  localparam int NMG = 1;
  localparam int NF = 6;
  localparam int BEW = RDW / 8;

  localparam logic [11:0] OFF_CFG_ERR = 12'h204;
  localparam logic [11:0] OFF_RATIO = 12'h208;
  localparam logic [11:0] OFF_PASS = 12'h240;
  localparam logic [11:0] OFF_FEXP = 12'h340;
  localparam logic [11:0] OFF_FRCV = 12'h440;
  localparam logic [11:0] OFF_DSEED = 12'h540;
  localparam logic [11:0] OFF_MSEED = 12'h580;
  localparam logic [11:0] OFF_DSEL = 12'h5c0;
  localparam logic [11:0] OFF_MSEL = 12'h600;
  localparam logic [11:0] OFF_INTV = 12'h640;
  localparam logic [11:0] OFF_TOPBIT = 12'h680;
  localparam logic [11:0] OFF_OVF = 12'h6c0;
  localparam logic [11:0] OFF_OVF_LO = 12'h700;
  localparam logic [11:0] OFF_OVF_HI = 12'h704;
  localparam logic [11:0] OFF_REREAD = 12'h740;
  localparam logic [11:0] OFF_CTRL = 12'h7c0;
  localparam logic [11:0] OFF_STAT = 12'h7c4;
  localparam logic [11:0] OFF_MODE = 12'h7c8;

  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE_ONCE_READ_MANY = 1;
  localparam int CTRL_BLEN_LO = 4;
  localparam int CTRL_OPS_LO = 8;
  localparam int CTRL_LOOPS_LO = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int ERR_FIELD0 = 0;
  localparam int ERR_TOPBIT = 1;

  localparam logic [3:0] WIDTH_RATIO_VAL = 4'h4;
  localparam logic [3:0] BLEN_RST = 4'h1;
  localparam logic [7:0] OPS_RST = 8'h04;
  localparam logic [7:0] LOOPS_RST = 8'h01;
  localparam logic [15:0] INTV_RST = 16'h0001;

  localparam logic [5:0] PAT_FIXED = 6'h00;
  localparam logic [5:0] PAT_PRBS7 = 6'h01;
  localparam logic [5:0] PAT_PRBS15 = 6'h02;
  localparam logic [5:0] PAT_PRBS31 = 6'h03;
  localparam logic [5:0] PAT_ROT = 6'h04;
  localparam logic [1:0] AMODE_FIXED = 2'h0;
  localparam logic [1:0] AMODE_RANDOM = 2'h1;
  localparam logic [1:0] AMODE_SEQ = 2'h2;
  localparam logic [1:0] AMODE_UNUSED = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WR_SET = 3'b001, ST_WR_BEAT = 3'b010,
    ST_RD_SET = 3'b011, ST_RD_CMD = 3'b100, ST_RD_BEAT = 3'b101,
    ST_WRITE_ONCE_READ_MANY_CMD = 3'b110, ST_WRITE_ONCE_READ_MANY_BEAT = 3'b111
  } tgs_state_t;

  typedef struct packed {
    logic psel; logic penable; logic pwrite;
    logic [11:0] paddr; logic [31:0] pwdata;
  } tgs_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata; logic pready; logic pslverr;
  } tgs_apb_rsp_t;
  typedef struct packed {
    logic valid; logic write; logic [AW-1:0] addr; logic [3:0] burst;
    logic [RDW-1:0] wdata; logic [BEW-1:0] byteen;
  } tgs_cmd_t;
  typedef struct packed {
    logic ready; logic rvalid; logic [RDW-1:0] rdata;
  } tgs_host_rsp_t;

  typedef struct packed {
    tgs_state_t st;
    tgs_apb_rsp_t apb;
    logic [NDG-1:0][31:0] dseed;
    logic [NDG-1:0][5:0] dsel;
    logic [NMG-1:0][31:0] mseed;
    logic [NMG-1:0][5:0] msel;
    logic [NF-1:0][15:0] intv;
    logic [NF-2:0][5:0] topbit;
    logic [NF-1:0][1:0] amode;
    logic write_once_read_many_en; logic [3:0] blen; logic [7:0] ops; logic [7:0] loops;
    logic [NDG-1:0][31:0] dst;
    logic [NDG-1:0][31:0] dsave;
    logic [NMG-1:0][31:0] mst;
    logic [NF-1:0][AW-1:0] fval;
    logic [NF-1:0][AW-1:0] fsave;
    logic [NF-1:0][15:0] fcnt;
    logic [NF-1:0][15:0] fcsave;
    logic [7:0] loop_left; logic [7:0] op_left;
    logic [3:0] beat_left; logic [3:0] cur_bl;
    tgs_cmd_t cmd;
    logic [RDW-1:0] pass_vec; logic [RDW-1:0] fexp;
    logic [RDW-1:0] frcv; logic [RDW-1:0] reread;
    logic failed; logic ovf;
    logic [AW-1:0] ovf_addr; logic [AW-1:0] ff_addr;
    logic busy; logic done;
  } tgs_regs_t;
endpackage

// *** verif/tgs_host_model.sv ***
/*
  tgs_host_model: behavioural memory behind the word-addressed host port.
  assumes: same clock and reset as tgs_top; slow_in stalls, flip_in
  corrupts bit 0 of returned read data.
*/
`timescale 1ns/1ps
module tgs_host_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic slow_in,
  input wire logic flip_in,
  input wire tgs_pkg::tgs_cmd_t cmd_in,
  output tgs_pkg::tgs_host_rsp_t rsp_out
);
  logic [63:0] mem [int];
  int q[$];
  int wcnt;
  int ph;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsp_out <= '0;
      q.delete();
      wcnt = 0;
      ph = 0;
    end else begin
      ph = ph + 1;
      rsp_out.ready <= !slow_in || ph[1];
      rsp_out.rvalid <= 1'b0;
      rsp_out.rdata <= ~rsp_out.rdata;
      if (cmd_in.valid && rsp_out.ready) begin
        if (cmd_in.write) begin
          mem[cmd_in.addr + wcnt] = cmd_in.wdata;
          wcnt = (wcnt + 1 >= cmd_in.burst) ? 0 : wcnt + 1;
        end else begin
          for (int i = 0; i < cmd_in.burst; i++) begin
            q.push_back(cmd_in.addr + i);
          end
        end
      end else if (q.size() > 0 && (!slow_in || ph[0])) begin
        rsp_out.rvalid <= 1'b1;
        rsp_out.rdata <= (mem.exists(q[0]) ? mem[q[0]] : 64'h0)
          ^ {63'h0, flip_in};
        void'(q.pop_front());
      end
    end
  end
endmodule

// *** verif/tgs_top_chk.sv ***
/*
  tgs_top_chk: port assertions for tgs_top.
  assumes: bound to tgs_top, one clock, active-low async reset.
*/
`timescale 1ns/1ps
module tgs_top_chk (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire tgs_pkg::tgs_apb_req_t APB_REQ_IN,
  input wire tgs_pkg::tgs_apb_rsp_t APB_RSP_OUT,
  input wire tgs_pkg::tgs_cmd_t HOST_CMD_OUT,
  input wire tgs_pkg::tgs_host_rsp_t HOST_RSP_IN
);
  wire rd_ok = APB_RSP_OUT.pready && !APB_REQ_IN.pwrite;
  wire [11:0] a = APB_REQ_IN.paddr;
  wire [31:0] d = APB_RSP_OUT.prdata;
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  chk_apb_answer:
    assert property (APB_REQ_IN.psel && APB_REQ_IN.penable
      && !APB_RSP_OUT.pready |=> APB_RSP_OUT.pready ##1 !APB_RSP_OUT.pready)
    else $error("apb answer timing wrong");
  chk_ratio_value:
    assert property (rd_ok && a == 12'h208 |-> d == 32'h4)
    else $error("width ratio wrong");
  chk_sel_width:
    assert property (rd_ok && (a == 12'h5c0 || a == 12'h600)
      |-> d[31:6] == 26'h0)
    else $error("pattern select too wide");
  chk_intv_width:
    assert property (rd_ok && a[11:6] == 6'h19 |-> d[31:16] == 16'h0)
    else $error("interval too wide");
  chk_flag_width:
    assert property (rd_ok && a == 12'h6c0 |-> d[31:1] == 31'h0)
    else $error("overrun flag too wide");
  chk_addr_high:
    assert property (rd_ok && a == 12'h704 |-> d == 32'h0)
    else $error("overrun high word not zero");
  chk_space_bound:
    assert property (HOST_CMD_OUT.valid |->
      {1'b0, HOST_CMD_OUT.addr} + HOST_CMD_OUT.burst <= 27'h4000000)
    else $error("command beyond address space");
  chk_cmd_hold:
    assert property (HOST_CMD_OUT.valid && !HOST_RSP_IN.ready |=>
      HOST_CMD_OUT.valid && $stable(HOST_CMD_OUT.addr))
    else $error("command dropped before ready");
endmodule
bind tgs_top tgs_top_chk u_chk (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN),
  .APB_REQ_IN(APB_REQ_IN), .APB_RSP_OUT(APB_RSP_OUT),
  .HOST_CMD_OUT(HOST_CMD_OUT), .HOST_RSP_IN(HOST_RSP_IN));

// *** verif/tb_tgs_top.sv ***
/*
  tb_tgs_top: register and traffic tests for tgs_top over APB.
  assumes: tgs_host_model stands in for the memory host port.
*/
`timescale 1ns/1ps
module tb_tgs_top;
  logic clk, nrst, slow, flip, perr;
  logic [31:0] rdat;
  logic wgo;
  logic [7:0] be_exp;
  int err_total, total_checks, nwr, nrd;
  logic [25:0] aq[$];
  tgs_pkg::tgs_apb_req_t req;
  tgs_pkg::tgs_apb_rsp_t rsp;
  tgs_pkg::tgs_cmd_t cmd;
  tgs_pkg::tgs_host_rsp_t hrsp;

  tgs_top u_dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .APB_REQ_IN(req),
    .APB_RSP_OUT(rsp), .HOST_CMD_OUT(cmd), .HOST_RSP_IN(hrsp));
  tgs_host_model u_host (.clk_in(clk), .nrst_in(nrst), .slow_in(slow),
    .flip_in(flip), .cmd_in(cmd), .rsp_out(hrsp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 64);
    if (n >= 64) err_total++;
    rdat = rsp.prdata;
    perr = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask

  task automatic start_run(input logic [31:0] ctrl);
    int n;
    n = 0;
    nwr = 0;
    nrd = 0;
    aq.delete();
    wr(12'h7c0, ctrl);
    do begin
      xfer(1'b0, 12'h7c4, 32'h0);
      n++;
    end while (rdat[tgs_pkg::STAT_DONE] !== 1'b1 && n < 300);
    if (n >= 300) err_total++;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (!cmd.valid) begin
      wgo = 1'b1;
    end else if (hrsp.ready && cmd.write && wgo) begin
      wgo = 1'b0;
      nwr++;
      aq.push_back(cmd.addr);
      check({24'h0, cmd.byteen}, {24'h0, be_exp});
    end else if (hrsp.ready && !cmd.write) begin
      nrd++;
      if (aq.size() > 0) begin
        check({6'h0, cmd.addr}, {6'h0, aq.pop_front()});
      end
    end
  end

  initial begin
    #200000;
    err_total++;
    end_of_test();
  end

  initial begin
    req = '0;
    nrst = 1'b0;
    slow = 1'b0;
    flip = 1'b0;
    be_exp = 8'hff;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(12'h208, 32'h4);
    rd(12'h654, 32'h1);
    rd(12'h6c0, 32'h0);
    rd(12'h704, 32'h0);
    rd(12'h244, 32'hffffffff);
    wr(12'h208, 32'h0);
    rd(12'h208, 32'h4);
    xfer(1'b0, 12'h7fc, 32'h0);
    check({31'h0, perr}, 32'h1);
    $display("test 1 done");
    for (int i = 0; i < 6; i++) begin
      wr(12'h5c0, 32'(i % 5));
      rd(12'h5c0, 32'(i % 5));
      wr(12'h600, 32'(i % 5));
      rd(12'h600, 32'(i % 5));
      wr(12'h640 + 12'(4 * i), 32'hfff00001);
      rd(12'h640 + 12'(4 * i), 32'h1);
    end
    for (int i = 0; i < 5; i++) begin
      wr(12'h680 + 12'(4 * i), 32'hffc3 + 32'(4 * i));
      rd(12'h680 + 12'(4 * i), 32'h3 + 32'(4 * i));
    end
    wr(12'h544, 32'h5a5a0f0f);
    rd(12'h544, 32'h5a5a0f0f);
    wr(12'h580, 32'hffffffff);
    rd(12'h580, 32'hffffffff);
    rd(12'h204, 32'h0);
    wr(12'h690, 32'h1e);
    rd(12'h204, 32'h2);
    wr(12'h690, 32'h13);
    $display("test 2 done");
    wr(12'h7c8, 32'h2);
    slow <= 1'b1;
    start_run(32'h00020411);
    check(nwr, 32'h8);
    check(nrd, 32'h8);
    rd(12'h7c4, 32'h2);
    rd(12'h240, 32'hffffffff);
    $display("test 3 done");
    flip <= 1'b1;
    start_run(32'h00010113);
    flip <= 1'b0;
    check(nrd, 32'h2);
    rd(12'h7c4, 32'h6);
    rd(12'h240, 32'hfffffffe);
    rd(12'h340, 32'h0);
    rd(12'h344, 32'h5a5a0f0f);
    rd(12'h440, 32'h1);
    rd(12'h444, 32'h5a5a0f0f);
    rd(12'h740, 32'h1);
    rd(12'h744, 32'h5a5a0f0f);
    $display("test 4 done");
    slow <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(12'h680 + 12'(4 * i), 32'(5 * i));
    end
    wr(12'h7c8, 32'haa8);
    start_run(32'h00012031);
    rd(12'h204, 32'h1);
    rd(12'h6c0, 32'h1);
    rd(12'h700, 32'h03fffffe);
    rd(12'h7c4, 32'h2);
    rd(12'h240, 32'hffffffff);
    rd(12'h440, 32'h0);
    check(nwr, 32'h20);
    check(nrd, 32'h20);
    $display("overflow test done");
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    be_exp = 8'h00;
    @(posedge clk);
    rd(12'h6c0, 32'h0);
    rd(12'h544, 32'h0);
    $display("reset test done");
    slow <= 1'b0;
    start_run(32'h00010111);
    rd(12'h240, 32'hffffffff);
    rd(12'h7c4, 32'h2);
    $display("test 5 done");
    end_of_test();
  end
endmodule
